// ===== pkg/meas_regs.svh
// register offsets, field positions and widths of the measurement bank
// Notes on behaviour
// - a twelve-bit value shows its bits 11..4 in its high byte, bit 11 at the top.
// - its low byte holds bits 3..0 in the upper nibble and reads zero in the lower nibble.
// - a power value shows its bits 23..16 in its top byte.
// - a power value shows its bits 15..8 in its middle byte, bit 15 at the top.
// - a power value shows its bits 7..0 in its bottom byte, with no reserved bits.
`ifndef MEAS_REGS_SVH
`define MEAS_REGS_SVH
`define CTRL_ADDR 8'h00
`define STAT_ADDR 8'h01
`define PWR_BASE 8'h20
`define CONV_BASE 8'h40
`define CONV_END 8'h70
`define PWR_SLOT 4:2
`define PWR_LANE 1:0
`define CONV_CHAN 5:4
`define CONV_SLOT 3:1
`define CONV_LANE 0
`define WE_BIT 4
`define SLOT_RESULT 3'h0
`define SLOT_MAX 3'h1
`define SLOT_MIN 3'h2
`define SLOT_THR_MAX 3'h3
`define SLOT_THR_MIN 3'h4
`define NUM_SLOTS 5
`define NUM_CONV 3
`define CONV_W 12
`define CONV_NB 2
`define PWR_W 24
`define PWR_NB 3
`define CONV_HI 11:4
`define CONV_LO 3:0
`define PWR_TOP 23:16
`define PWR_MID 15:8
`define PWR_BOT 7:0
`define ALARM_PWR_OVER 7
`define ALARM_PWR_UNDER 6
`define UNMAPPED_DATA 8'h00
`endif

// ===== pkg/meas_pkg.sv
// shared types of the measurement bank
`include "meas_regs.svh"
package meas_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [`NUM_CONV-1:0] conv_valid;
    logic [`NUM_CONV-1:0][`CONV_W-1:0] conv_sample;
    logic pwr_valid;
    logic [`PWR_W-1:0] pwr_sample;
  } meas_in_s;

  typedef enum logic [4:0] {
    TGT_NONE = 5'h01,
    TGT_CTRL = 5'h02,
    TGT_STAT = 5'h04,
    TGT_PWR = 5'h08,
    TGT_CONV = 5'h10
  } target_e;

  typedef struct packed {
    target_e tgt;
    logic [1:0] chan;
    logic [2:0] slot;
    logic [1:0] lane;
  } dec_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic we;
    logic [7:0] alarm;
  } top_state_s;
endpackage

// ===== logic/byte_lane_pick.sv
// picks one byte lane of a stored value, value left-justified over its bytes
`timescale 1ns/1ns
`include "meas_regs.svh"
module byte_lane_pick #(
  parameter int W = `CONV_W,
  parameter int NB = `CONV_NB
) (
  // stored values
  input wire logic [`NUM_SLOTS-1:0][W-1:0] slots,
  // selection
  input wire logic [2:0] slot,
  input wire logic [1:0] lane,
  // picked byte
  output logic [7:0] lane_byte
);
  import meas_pkg::*;
  localparam int PW = NB * 8;
  logic [PW-1:0] padded;

  always_comb begin
    padded = '0;
    lane_byte = `UNMAPPED_DATA;
    if (slot < 3'(`NUM_SLOTS) && lane < 2'(NB)) begin
      padded[PW-1 -: W] = slots[slot];
      lane_byte = padded[(NB - 1 - int'(lane)) * 8 +: 8];
    end
  end
endmodule

// ===== logic/meas_tracker.sv
// result, min/max and threshold store for one measured quantity
`timescale 1ns/1ns
`include "meas_regs.svh"
module meas_tracker #(
  parameter int W = `CONV_W,
  parameter int NB = `CONV_NB
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // new sample
  input wire logic smp_valid,
  input wire logic [W-1:0] smp,
  // host byte write
  input wire logic wr_stb,
  input wire logic [2:0] wr_slot,
  input wire logic [1:0] wr_lane,
  input wire logic [7:0] wr_data,
  input wire logic meas_write_enable_bit,
  // stored values and threshold compare
  output logic [`NUM_SLOTS-1:0][W-1:0] slots,
  output logic over,
  output logic under
);
  import meas_pkg::*;
  localparam int PW = NB * 8;
  typedef struct packed {
    logic [`NUM_SLOTS-1:0][W-1:0] v;
  } trk_state_s;
  trk_state_s st_ff;
  trk_state_s nxt_st;
  logic [PW-1:0] padded;
  logic wr_ok;

  always_comb begin
    nxt_st = st_ff;
    padded = '0;
    wr_ok = wr_stb && (meas_write_enable_bit || wr_slot >= `SLOT_THR_MAX);
    if (smp_valid) begin
      nxt_st.v[`SLOT_RESULT] = smp;
      if (smp > st_ff.v[`SLOT_MAX]) begin
        nxt_st.v[`SLOT_MAX] = smp;
      end
      if (smp < st_ff.v[`SLOT_MIN]) begin
        nxt_st.v[`SLOT_MIN] = smp;
      end
    end
    if (wr_ok && wr_slot < 3'(`NUM_SLOTS) && wr_lane < 2'(NB)) begin
      padded[PW-1 -: W] = nxt_st.v[wr_slot];
      padded[(NB - 1 - int'(wr_lane)) * 8 +: 8] = wr_data;
      nxt_st.v[wr_slot] = padded[PW-1 -: W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_ff.v <= '0;
      st_ff.v[`SLOT_MIN] <= '1;
      st_ff.v[`SLOT_THR_MAX] <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign slots = st_ff.v;
  assign over = st_ff.v[`SLOT_RESULT] > st_ff.v[`SLOT_THR_MAX];
  assign under = st_ff.v[`SLOT_RESULT] < st_ff.v[`SLOT_THR_MIN];

  a_locked_result: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_stb && !meas_write_enable_bit && wr_slot < `SLOT_THR_MAX && !smp_valid
    |=> $stable(st_ff.v))
    else $error("locked value changed by host write");
endmodule

// ===== logic/meas_bank.sv
// measurement register bank: byte access to converter and power values
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "meas_regs.svh"
module meas_bank (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire meas_pkg::reg_req_s reg_req,
  output logic [7:0] rdata,
  // measured samples
  input wire meas_pkg::meas_in_s meas_in,
  // state seen outside
  output logic meas_write_enable_bit,
  output logic [7:0] alarm
);
  import meas_pkg::*;

  top_state_s st_ff;
  top_state_s nxt_st;
  dec_s dec;
  logic pwr_wr;
  logic pwr_over;
  logic pwr_under;
  logic [7:0] pwr_byte;
  logic [`PWR_W-1:0] pwr_slots [`NUM_SLOTS];
  logic [`NUM_SLOTS-1:0][`PWR_W-1:0] pwr_vec;
  logic [`NUM_CONV-1:0][`NUM_SLOTS-1:0][`CONV_W-1:0] conv_slots;
  logic [`NUM_CONV-1:0][7:0] conv_byte;
  logic [`NUM_CONV-1:0] conv_wr;
  logic [`NUM_CONV-1:0] conv_over;
  logic [`NUM_CONV-1:0] conv_under;
  logic [7:0] nxt_alarm;

  function automatic dec_s decode(input logic [7:0] a);
    dec_s d;
    logic [7:0] off;
    d.tgt = TGT_NONE;
    d.chan = 2'h0;
    d.slot = 3'h0;
    d.lane = 2'h0;
    off = 8'h00;
    if (a == `CTRL_ADDR) begin
      d.tgt = TGT_CTRL;
    end else if (a == `STAT_ADDR) begin
      d.tgt = TGT_STAT;
    end else if (a >= `PWR_BASE && a < `CONV_BASE) begin
      off = a - `PWR_BASE;
      d.slot = off[`PWR_SLOT];
      d.lane = off[`PWR_LANE];
      if (d.slot < 3'(`NUM_SLOTS) && d.lane < 2'(`PWR_NB)) begin
        d.tgt = TGT_PWR;
      end
    end else if (a >= `CONV_BASE && a < `CONV_END) begin
      off = a - `CONV_BASE;
      d.chan = off[`CONV_CHAN];
      d.slot = off[`CONV_SLOT];
      d.lane = {1'b0, off[`CONV_LANE]};
      if (d.slot < 3'(`NUM_SLOTS)) begin
        d.tgt = TGT_CONV;
      end
    end
    return d;
  endfunction

  assign dec = decode(reg_req.addr);
  assign pwr_wr = reg_req.wr && dec.tgt == TGT_PWR;

  meas_tracker #(.W(`PWR_W), .NB(`PWR_NB)) u_pwr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .smp_valid(meas_in.pwr_valid),
    .smp(meas_in.pwr_sample),
    .wr_stb(pwr_wr),
    .wr_slot(dec.slot),
    .wr_lane(dec.lane),
    .wr_data(reg_req.wdata),
    .meas_write_enable_bit(st_ff.we),
    .slots(pwr_vec),
    .over(pwr_over),
    .under(pwr_under)
  );

  byte_lane_pick #(.W(`PWR_W), .NB(`PWR_NB)) u_pwr_pick (
    .slots(pwr_vec),
    .slot(dec.slot),
    .lane(dec.lane),
    .lane_byte(pwr_byte)
  );

  genvar gs;
  generate
    for (gs = 0; gs < `NUM_SLOTS; gs++) begin : g_pwr_view
      assign pwr_slots[gs] = pwr_vec[gs];
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < `NUM_CONV; gc++) begin : g_conv
      assign conv_wr[gc] = reg_req.wr && dec.tgt == TGT_CONV && dec.chan == 2'(gc);

      meas_tracker #(.W(`CONV_W), .NB(`CONV_NB)) u_trk (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .smp_valid(meas_in.conv_valid[gc]),
        .smp(meas_in.conv_sample[gc]),
        .wr_stb(conv_wr[gc]),
        .wr_slot(dec.slot),
        .wr_lane(dec.lane),
        .wr_data(reg_req.wdata),
        .meas_write_enable_bit(st_ff.we),
        .slots(conv_slots[gc]),
        .over(conv_over[gc]),
        .under(conv_under[gc])
      );

      byte_lane_pick #(.W(`CONV_W), .NB(`CONV_NB)) u_pick (
        .slots(conv_slots[gc]),
        .slot(dec.slot),
        .lane(dec.lane),
        .lane_byte(conv_byte[gc])
      );

      assign nxt_alarm[2 * gc + 1] = conv_over[gc];
      assign nxt_alarm[2 * gc] = conv_under[gc];
    end
  endgenerate

  assign nxt_alarm[`ALARM_PWR_OVER] = pwr_over;
  assign nxt_alarm[`ALARM_PWR_UNDER] = pwr_under;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = `UNMAPPED_DATA;
    nxt_st.alarm = nxt_alarm;
    if (reg_req.wr && dec.tgt == TGT_CTRL) begin
      nxt_st.we = reg_req.wdata[`WE_BIT];
    end
    if (reg_req.rd) begin
      if (dec.tgt == TGT_CTRL) begin
        nxt_st.rdata[`WE_BIT] = st_ff.we;
      end else if (dec.tgt == TGT_STAT) begin
        nxt_st.rdata = st_ff.alarm;
      end else if (dec.tgt == TGT_PWR) begin
        nxt_st.rdata = pwr_byte;
      end else if (dec.tgt == TGT_CONV && dec.chan < 2'(`NUM_CONV)) begin
        nxt_st.rdata = conv_byte[dec.chan];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign meas_write_enable_bit = st_ff.we;
  assign alarm = st_ff.alarm;

  sequence s_rd_at(logic [7:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  sequence s_locked_pwr_wr;
    reg_req.wr && !st_ff.we && reg_req.addr == `PWR_BASE && !meas_in.pwr_valid;
  endsequence

  sequence s_open_wr(logic [7:0] a);
    reg_req.wr && st_ff.we && reg_req.addr == a;
  endsequence

  sequence s_shut_wr(logic [7:0] a);
    reg_req.wr && !st_ff.we && reg_req.addr == a;
  endsequence

  sequence s_rd_conv_low;
    reg_req.rd && dec.tgt == TGT_CONV && dec.lane[0];
  endsequence

  a_conv_high_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`CONV_BASE) |=> rdata == $past(conv_slots[0][`SLOT_RESULT][`CONV_HI]))
    else $error("converter high byte wrong");

  a_conv_low_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`CONV_BASE + 8'h01)
    |=> rdata == {$past(conv_slots[0][`SLOT_RESULT][`CONV_LO]), 4'h0})
    else $error("converter low byte wrong");

  a_power_top_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE) |=> rdata == $past(pwr_slots[`SLOT_RESULT][`PWR_TOP]))
    else $error("power top byte wrong");

  a_power_middle_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE + 8'h01) |=> rdata == $past(pwr_slots[`SLOT_RESULT][`PWR_MID]))
    else $error("power middle byte wrong");

  a_power_bottom_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE + 8'h02) |=> rdata == $past(pwr_slots[`SLOT_RESULT][`PWR_BOT]))
    else $error("power bottom byte wrong");

  a_locked_power: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_locked_pwr_wr |=> pwr_slots[`SLOT_RESULT] == $past(pwr_slots[`SLOT_RESULT]))
    else $error("locked power result was written");

  a_threshold_open: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_shut_wr(`PWR_BASE + 8'h0E)
    |=> pwr_slots[`SLOT_THR_MAX][`PWR_BOT] == $past(reg_req.wdata))
    else $error("threshold write was refused");

  a_conv_mid_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`CONV_BASE + 8'h10)
    |=> rdata == $past(conv_slots[1][`SLOT_RESULT][`CONV_HI]))
    else $error("second converter high byte wrong");

  a_conv_last_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`CONV_BASE + 8'h20)
    |=> rdata == $past(conv_slots[2][`SLOT_RESULT][`CONV_HI]))
    else $error("third converter high byte wrong");

  a_conv_max_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`CONV_BASE + 8'h02)
    |=> rdata == $past(conv_slots[0][`SLOT_MAX][`CONV_HI]))
    else $error("converter maximum high byte wrong");

  a_conv_thr_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`CONV_BASE + 8'h06)
    |=> rdata == $past(conv_slots[0][`SLOT_THR_MAX][`CONV_HI]))
    else $error("converter threshold high byte wrong");

  a_conv_mid_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`CONV_BASE + 8'h11)
    |=> rdata == {$past(conv_slots[1][`SLOT_RESULT][`CONV_LO]), 4'h0})
    else $error("second converter low byte wrong");

  a_conv_min_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`CONV_BASE + 8'h05)
    |=> rdata == {$past(conv_slots[0][`SLOT_MIN][`CONV_LO]), 4'h0})
    else $error("converter minimum low byte wrong");

  a_reserved_nibble: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_conv_low
    |=> rdata[3:0] == 4'h0)
    else $error("reserved converter bits read nonzero");

  a_power_max_top: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE + 8'h04)
    |=> rdata == $past(pwr_slots[`SLOT_MAX][`PWR_TOP]))
    else $error("power maximum top byte wrong");

  a_power_thr_top: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE + 8'h10)
    |=> rdata == $past(pwr_slots[`SLOT_THR_MIN][`PWR_TOP]))
    else $error("power threshold top byte wrong");

  a_power_min_middle: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE + 8'h09)
    |=> rdata == $past(pwr_slots[`SLOT_MIN][`PWR_MID]))
    else $error("power minimum middle byte wrong");

  a_power_thr_middle: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE + 8'h0D)
    |=> rdata == $past(pwr_slots[`SLOT_THR_MAX][`PWR_MID]))
    else $error("power threshold middle byte wrong");

  a_power_max_bottom: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE + 8'h06)
    |=> rdata == $past(pwr_slots[`SLOT_MAX][`PWR_BOT]))
    else $error("power maximum bottom byte wrong");

  a_power_thr_bottom: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rd_at(`PWR_BASE + 8'h12)
    |=> rdata == $past(pwr_slots[`SLOT_THR_MIN][`PWR_BOT]))
    else $error("power threshold bottom byte wrong");

  a_locked_conv: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_shut_wr(`CONV_BASE) ##0 !meas_in.conv_valid[0]
    |=> conv_slots[0][`SLOT_RESULT] == $past(conv_slots[0][`SLOT_RESULT]))
    else $error("locked converter result was written");

  a_locked_conv_max: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_shut_wr(`CONV_BASE + 8'h03) ##0 !meas_in.conv_valid[0]
    |=> conv_slots[0][`SLOT_MAX] == $past(conv_slots[0][`SLOT_MAX]))
    else $error("locked converter maximum was written");

  a_open_conv_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_open_wr(`CONV_BASE)
    |=> conv_slots[0][`SLOT_RESULT][`CONV_HI] == $past(reg_req.wdata))
    else $error("enabled converter write was lost");

  a_open_conv_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_open_wr(`CONV_BASE + 8'h01)
    |=> conv_slots[0][`SLOT_RESULT][`CONV_LO] == $past(reg_req.wdata[7:4]))
    else $error("converter low byte write misplaced");

  a_open_power_min: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_open_wr(`PWR_BASE + 8'h0A)
    |=> pwr_slots[`SLOT_MIN][`PWR_BOT] == $past(reg_req.wdata))
    else $error("enabled power write was lost");

  a_conv_thr_open: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_shut_wr(`CONV_BASE + 8'h09)
    |=> conv_slots[0][`SLOT_THR_MIN][`CONV_LO] == $past(reg_req.wdata[7:4]))
    else $error("converter threshold write was refused");
endmodule

// ===== tb/host_model.sv
// host side model driving the register port of the measurement bank
`timescale 1ns/1ns
`include "meas_regs.svh"
module host_model (
  // clock
  input wire logic ref_clk,
  // register port
  output meas_pkg::reg_req_s reg_req,
  input wire logic [7:0] rdata
);
  import meas_pkg::*;
  initial reg_req = '0;
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d, output logic [7:0] z);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    #1 d = rdata;
    @(posedge ref_clk);
    #1 z = rdata;
  endtask
  // result, maximum and minimum values are written only behind a set enable bit
  task automatic store_wr(input logic [7:0] a, input logic [7:0] d);
    bus_wr(`CTRL_ADDR, 8'h10);
    bus_wr(a, d);
  endtask
endmodule

// ===== tb/test_meas_bank.sv
// self-checking bench of the measurement register bank
`timescale 1ns/1ns
`include "meas_regs.svh"
module test_meas_bank;
  import meas_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  reg_req_s reg_req;
  meas_in_s meas_in = '0;
  logic [7:0] rdata;
  logic [7:0] alarm;
  logic meas_write_enable_bit;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int val[4][5];
  bit we;
  always #50 ref_clk = ~ref_clk;
  meas_bank meas_bank_i (.ref_clk(ref_clk), .rstn(rstn), .reg_req(reg_req), .rdata(rdata),
    .meas_in(meas_in), .meas_write_enable_bit(meas_write_enable_bit), .alarm(alarm));
  host_model host_model_i (.ref_clk(ref_clk), .reg_req(reg_req), .rdata(rdata));
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(logic [7:0] seen, logic [7:0] exp_v);
    samples_checked++;
    if (seen !== exp_v) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp_v);
    end
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    we = 0;
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 5; s++) begin
        val[k][s] = (s == 2 || s == 3) ? (k == 3 ? 'hFFFFFF : 'hFFF) : 0;
      end
    end
  endtask
  function automatic logic [7:0] mdl_rd(int a);
    int k, s, l, al;
    al = 0;
    for (k = 0; k < 4; k++) begin
      if (val[k][0] > val[k][3]) al = al | (k == 3 ? 'h80 : 2 << (2 * k));
      if (val[k][0] < val[k][4]) al = al | (k == 3 ? 'h40 : 1 << (2 * k));
    end
    if (a == 0) return we ? 8'h10 : 8'h00;
    if (a == 1) return 8'(al);
    if (a >= 'h20 && a < 'h40) begin
      s = (a - 'h20) >> 2;
      l = a & 3;
      if (s < 5 && l < 3) return 8'(val[3][s] >> (8 * (2 - l)));
    end
    if (a >= 'h40 && a < 'h70) begin
      k = (a - 'h40) >> 4;
      s = (a >> 1) & 7;
      if (s < 5) return (a & 1) ? 8'(val[k][s] << 4) : 8'(val[k][s] >> 4);
    end
    return 8'h00;
  endfunction
  function automatic void mdl_wr(int a, int d);
    int k, s, l;
    if (a == 0) we = d[4];
    if (a >= 'h20 && a < 'h40) begin
      s = (a - 'h20) >> 2;
      l = 8 * (2 - (a & 3));
      if (s < 5 && (a & 3) < 3 && (s > 2 || we))
        val[3][s] = (val[3][s] & ~('hFF << l)) | (d << l);
    end
    if (a >= 'h40 && a < 'h70) begin
      k = (a - 'h40) >> 4;
      s = (a >> 1) & 7;
      if (s < 5 && (s > 2 || we))
        val[k][s] = (a & 1) ? (val[k][s] & 'hFF0) | (d >> 4) : (val[k][s] & 'hF) | (d << 4);
    end
  endfunction
  task automatic sweep(string name);
    logic [7:0] d, z;
    for (int a = 0; a < 'h80; a++) begin
      host_model_i.bus_rd(8'(a), d, z);
      chk(d, mdl_rd(a));
      chk(z, 8'h00);
    end
    chk({7'h00, meas_write_enable_bit}, {7'h00, we});
    chk(alarm, mdl_rd(1));
    $display("test %s done", name);
  endtask
  task automatic write_all(bit en);
    logic [7:0] d;
    for (int a = 1; a < 'h80; a++) begin
      d = 8'($urandom_range(0, 255));
      if (en)
        host_model_i.store_wr(8'(a), d);
      else
        host_model_i.bus_wr(8'(a), d);
      if (en) mdl_wr(0, 'h10);
      mdl_wr(a, d);
    end
  endtask
  function automatic void upd(int k, int v);
    val[k][0] = v;
    if (v > val[k][1]) val[k][1] = v;
    if (v < val[k][2]) val[k][2] = v;
  endfunction
  task automatic samples(int n);
    meas_in_s m;
    repeat (n) begin
      @(posedge ref_clk);
      m.conv_valid = 3'($urandom_range(0, 7));
      m.pwr_valid = 1'($urandom_range(0, 1));
      m.pwr_sample = 24'($urandom);
      for (int c = 0; c < 3; c++) begin
        m.conv_sample[c] = 12'($urandom);
        if (m.conv_valid[c]) upd(c, m.conv_sample[c]);
      end
      if (m.pwr_valid) upd(3, m.pwr_sample);
      meas_in <= m;
    end
    @(posedge ref_clk);
    meas_in <= '0;
  endtask
  initial begin
    void'($urandom(33183));
    do_reset();
    sweep("reset");
    write_all(1'b0);
    sweep("locked writes");
    write_all(1'b1);
    sweep("enabled writes");
    samples(40);
    sweep("samples");
    do_reset();
    sweep("second reset");
    final_report();
  end
endmodule
